/* File: logic/wdc_pkg.sv */
// wdc_pkg: register map, field positions and reset values of the watchdog
// assumes a 32-bit APB slave with one aligned word per register
`default_nettype none
package wdc_pkg;
	localparam int CNT_W = 24;
	localparam int DIV_W = 9;
	localparam int NSCR  = 8;
	localparam logic [7:0] OFS_CTRL   = 8'h00;
	localparam logic [7:0] OFS_LOAD   = 8'h04;
	localparam logic [7:0] OFS_COUNT  = 8'h08;
	localparam logic [7:0] OFS_CAUSE  = 8'h0c;
	localparam logic [7:0] OFS_TICK   = 8'h10;
	localparam logic [7:0] OFS_BPC    = 8'h14;
	localparam logic [7:0] OFS_BSP    = 8'h18;
	localparam logic [7:0] OFS_ISTAT  = 8'h1c;
	localparam logic [7:0] OFS_IEN    = 8'h20;
	localparam logic [7:0] OFS_ICLR   = 8'h24;
	localparam logic [7:0] OFS_SCR0   = 8'h40;
	localparam logic [7:0] OFS_SCRMSK = 8'he0;
	localparam int CTRL_EN    = 0;
	localparam int CTRL_PAUSE = 1;
	localparam int CTRL_FORCE = 2;
	localparam int CAUSE_TMO  = 0;
	localparam int CAUSE_FRC  = 1;
	localparam int TICK_EN    = DIV_W;
	localparam int TICK_RUN   = DIV_W + 1;
	localparam int EV_TMO     = 0;
	localparam int EV_FRC     = 1;
	localparam int EV_RELOAD  = 2;
	localparam int NEV        = 3;
	localparam logic [DIV_W-1:0] RST_DIV  = 9'h00c;
	localparam logic [CNT_W-1:0] RST_LOAD = 24'hffffff;
endpackage
`default_nettype wire

/* File: logic/wdc_top.sv */
// wdc_top: watchdog countdown with crystal-derived tick, cause and boot vector
// assumes APB on MCLK; XOSC_IN and DBG_HALT arrive asynchronously from pins
//
// What this block does
// [R1] counter decrements per tick, zero restarts chip
// [R2] update write reloads counter with load value
// [R3] crystal divided by programmable count gives tick
// [R4] counter advances exactly once per generated tick
// [R5] software keeps timeout at most 8388 ms
// [R6] pause option stops counting during debug halt
// [R7] cause reads true after timeout or force
// [R8] cause false since power-on reset only
// [R9] software marks scratch 4, reboot keeps it; only NRST clears it
// [R10] zero boot pc means standard boot
// [R11] current count readable as remaining microseconds
// [R12] force triggers reset, enable gates timeouts
`default_nettype none
module wdc_top #(
	parameter int CNT_W = wdc_pkg::CNT_W,
	parameter int DIV_W = wdc_pkg::DIV_W
) (
	input  wire logic        MCLK,
	input  wire logic        NRST,
	input  wire logic        CE,
	input  wire logic        XOSC_IN,
	input  wire logic        DBG_HALT,
	input  wire logic        PSEL,
	input  wire logic        PENABLE,
	input  wire logic        PWRITE,
	input  wire logic [7:0]  PADDR,
	input  wire logic [31:0] PWDATA,
	output logic      [31:0] PRDATA,
	output logic             PREADY,
	output logic             PSLVERR,
	output logic             CHIP_RESTART,
	output logic             BOOT_JUMP,
	output logic      [31:0] BOOT_PC,
	output logic      [31:0] BOOT_SP,
	output logic             IRQ
);
	typedef struct packed {
		logic [2:0]               xs;
		logic [1:0]               ds;
		logic [DIV_W-1:0]         div;
		logic                     tick_en;
		logic [DIV_W-1:0]         dcnt;
		logic                     en;
		logic                     pause;
		logic [CNT_W-1:0]         load;
		logic [CNT_W-1:0]         cnt;
		logic [1:0]               cause;
		logic [31:0]              bpc;
		logic [31:0]              bsp;
		logic [wdc_pkg::NEV-1:0]  istat;
		logic [wdc_pkg::NEV-1:0]  ien;
		logic [wdc_pkg::NSCR-1:0][31:0] scr;
		logic [31:0]              prdata;
		logic                     pready;
		logic                     pslverr;
		logic                     restart;
		logic                     jump;
		logic [31:0]              opc;
		logic [31:0]              osp;
		logic                     irq;
	} wdc_state_t;

	wdc_state_t s;
	wdc_state_t next_s;

	logic tick;
	logic wr;
	logic xedge;
	logic count_ok;
	logic fire_tmo;
	logic fire_frc;
	logic [wdc_pkg::NEV-1:0] ev;
	logic [2:0] sidx;

	always_comb begin
		next_s = s;
		// xs[0] feeds only xs[1]; edge taken between the second and third flop
		next_s.xs = {s.xs[1:0], XOSC_IN};
		next_s.ds = {s.ds[0], DBG_HALT};
		xedge = s.xs[1] & ~s.xs[2];
		tick = 1'b0;
		if (!s.tick_en || s.div == '0) begin
			next_s.dcnt = '0;
		end else if (xedge) begin
			if (s.dcnt >= s.div - DIV_W'(1)) begin // R3
				next_s.dcnt = '0;
				tick = 1'b1;
			end else begin
				next_s.dcnt = s.dcnt + DIV_W'(1);
			end
		end

		wr = PSEL & PENABLE & s.pready & PWRITE;
		sidx = PADDR[4:2];
		fire_frc = 1'b0;
		ev = '0;

		// pausing only holds the count; a pending reload still applies
		count_ok = s.en & ~(s.pause & s.ds[1]); // R6
		if (count_ok && tick && s.cnt != '0) begin
			next_s.cnt = s.cnt - CNT_W'(1); // R1 R4
		end
		fire_tmo = s.en & (s.cnt == '0); // R1 R12

		if (wr) begin
			case (PADDR)
				wdc_pkg::OFS_CTRL: begin
					next_s.en = PWDATA[wdc_pkg::CTRL_EN]; // R12
					next_s.pause = PWDATA[wdc_pkg::CTRL_PAUSE];
					fire_frc = PWDATA[wdc_pkg::CTRL_FORCE]; // R12
					if (PWDATA[wdc_pkg::CTRL_EN] && !s.en) begin
						next_s.cnt = s.load;
					end
				end
				wdc_pkg::OFS_LOAD: begin
					// update write: the written value becomes the load value and reloads the count
					next_s.load = PWDATA[CNT_W-1:0]; // R2
					next_s.cnt = PWDATA[CNT_W-1:0]; // R2
					ev[wdc_pkg::EV_RELOAD] = 1'b1;
				end
				wdc_pkg::OFS_TICK: begin
					next_s.div = PWDATA[DIV_W-1:0]; // R3
					next_s.tick_en = PWDATA[wdc_pkg::TICK_EN];
				end
				wdc_pkg::OFS_BPC: next_s.bpc = PWDATA; // R10
				wdc_pkg::OFS_BSP: next_s.bsp = PWDATA;
				wdc_pkg::OFS_IEN: next_s.ien = PWDATA[wdc_pkg::NEV-1:0];
				wdc_pkg::OFS_ICLR: next_s.istat = s.istat & ~PWDATA[wdc_pkg::NEV-1:0];
				default: begin
					if ((PADDR & wdc_pkg::OFS_SCRMSK) == wdc_pkg::OFS_SCR0) begin
						next_s.scr[sidx] = PWDATA; // R9
					end
				end
			endcase
		end

		next_s.restart = 1'b0;
		if (fire_tmo || fire_frc) begin
			next_s.restart = 1'b1; // R1 R12
			// the reboot clears the enable so the restart is a single pulse
			next_s.en = 1'b0;
			next_s.cnt = s.load;
			// cause survives everything but NRST, which is the power-on reset
			next_s.cause = {fire_frc, fire_tmo & ~fire_frc}; // R7 R8
			next_s.jump = (s.bpc != '0); // R10
			next_s.opc = s.bpc; // R10
			next_s.osp = s.bsp; // R10
			ev[wdc_pkg::EV_TMO] = fire_tmo & ~fire_frc;
			ev[wdc_pkg::EV_FRC] = fire_frc;
		end
		// a new event wins over a clear in the same cycle
		next_s.istat = next_s.istat | ev;
		next_s.irq = |(next_s.istat & s.ien);

		next_s.pready = PSEL & ~PENABLE & ~s.pready;
		if (PSEL && !PENABLE) begin
			next_s.pslverr = 1'b0;
			next_s.prdata = '0;
			case (PADDR)
				wdc_pkg::OFS_CTRL:
					next_s.prdata = {29'h0, 1'b0, s.pause, s.en};
				wdc_pkg::OFS_LOAD: next_s.prdata = 32'(s.load);
				wdc_pkg::OFS_COUNT: next_s.prdata = 32'(s.cnt); // R11
				wdc_pkg::OFS_CAUSE: next_s.prdata = {30'h0, s.cause}; // R7
				wdc_pkg::OFS_TICK:
					next_s.prdata = {21'h0, count_ok, s.tick_en, s.div};
				wdc_pkg::OFS_BPC: next_s.prdata = s.bpc;
				wdc_pkg::OFS_BSP: next_s.prdata = s.bsp;
				wdc_pkg::OFS_ISTAT: next_s.prdata = 32'(s.istat);
				wdc_pkg::OFS_IEN: next_s.prdata = 32'(s.ien);
				wdc_pkg::OFS_ICLR: next_s.prdata = '0;
				default: begin
					if ((PADDR & wdc_pkg::OFS_SCRMSK) == wdc_pkg::OFS_SCR0) begin
						next_s.prdata = s.scr[sidx];
					end else begin
						next_s.pslverr = 1'b1;
					end
				end
			endcase
		end
	end

	always_ff @(posedge MCLK) begin
		if (!NRST) begin
			s <= '0;
			s.div <= wdc_pkg::RST_DIV;
			s.load <= wdc_pkg::RST_LOAD;
			s.cnt <= wdc_pkg::RST_LOAD;
		end else if (CE) begin
			s <= next_s;
		end
	end

	assign PRDATA = s.prdata;
	assign PREADY = s.pready;
	assign PSLVERR = s.pslverr;
	assign CHIP_RESTART = s.restart;
	assign BOOT_JUMP = s.jump;
	assign BOOT_PC = s.opc;
	assign BOOT_SP = s.osp;
	assign IRQ = s.irq;
endmodule
`default_nettype wire

/* File: dv/wdc_assertions.sv */
// wdc_chk: port-level properties of the watchdog top
// assumes one MCLK domain and CE held high by the bench
`default_nettype none
module wdc_chk (
	input wire logic        MCLK,
	input wire logic        NRST,
	input wire logic        PSEL,
	input wire logic        PENABLE,
	input wire logic        PWRITE,
	input wire logic [7:0]  PADDR,
	input wire logic [31:0] PWDATA,
	input wire logic        PREADY,
	input wire logic        PSLVERR,
	input wire logic        CHIP_RESTART,
	input wire logic        IRQ
);
	default clocking @(posedge MCLK);
	endclocking
	default disable iff (!NRST);
	sequence setup_s;
		PSEL && !PENABLE;
	endsequence
	sequence frc_s;
		PREADY && PWRITE && PADDR == 8'h00 && PWDATA[2];
	endsequence
	ready_one_a: assert property (setup_s ##1 PENABLE |-> PREADY)
		else $error("access phase not answered in one cycle");
	ready_pulse_a: assert property (PREADY |=> !PREADY)
		else $error("ready held past one cycle");
	bad_addr_a: assert property (PREADY && PADDR == 8'h30 |-> PSLVERR)
		else $error("unmapped access without error");
	good_addr_a: assert property (PREADY && PADDR == 8'h0c |-> !PSLVERR)
		else $error("mapped access flagged as error");
	force_rst_a: assert property (frc_s |=> CHIP_RESTART)
		else $error("force write gave no restart");
	rst_pulse_a: assert property (CHIP_RESTART |=> !CHIP_RESTART)
		else $error("restart longer than one cycle");
	boot_quiet_a: assert property ($rose(NRST) |-> !CHIP_RESTART [*8])
		else $error("restart while disabled after reset");
	rst_clear_a: assert property (disable iff (1'b0) !NRST |=> !CHIP_RESTART && !IRQ)
		else $error("outputs not cleared by reset");
endmodule
bind wdc_top wdc_chk u_chk (.MCLK(MCLK), .NRST(NRST), .PSEL(PSEL), .PENABLE(PENABLE),
	.PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
	.CHIP_RESTART(CHIP_RESTART), .IRQ(IRQ));
`default_nettype wire

/* File: dv/test_watchdog_countdown_reset.sv */
// test_watchdog_countdown_reset: APB-driven checks of the watchdog
// assumes the crystal toggles every MCLK, so one tick is 24 MCLK at div 12
`default_nettype none
module test_watchdog_countdown_reset;
	timeunit 1ns;
	timeprecision 100ps;
	logic        MCLK = 0, NRST = 0, XOSC_IN = 0, DBG_HALT = 0;
	logic        PSEL = 0, PENABLE = 0, PWRITE = 0, PREADY, PSLVERR, err;
	logic        CHIP_RESTART, BOOT_JUMP, IRQ;
	logic [7:0]  PADDR = 0;
	logic [31:0] PWDATA = 0, PRDATA, BOOT_PC, BOOT_SP, rd;
	int          errors = 0, checked = 0, n, c;
	wdc_top i_dut (.MCLK(MCLK), .NRST(NRST), .CE(1'b1), .XOSC_IN(XOSC_IN),
		.DBG_HALT(DBG_HALT), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
		.PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
		.PSLVERR(PSLVERR), .CHIP_RESTART(CHIP_RESTART), .BOOT_JUMP(BOOT_JUMP),
		.BOOT_PC(BOOT_PC), .BOOT_SP(BOOT_SP), .IRQ(IRQ));
	initial forever #12.5 MCLK = ~MCLK;
	always @(posedge MCLK) XOSC_IN <= ~XOSC_IN;
	task automatic end_sim;
		$display("checked %0d errors %0d", checked, errors);
		if (errors == 0 && checked > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	task automatic chk(string nm, logic [31:0] s, logic [31:0] e);
		checked++;
		if (s !== e) begin
			errors++;
			$display("ERROR %s exp %h seen %h", nm, e, s);
		end
	endtask
	// ready is read right after a rising edge, before that edge's updates land
	task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
		@(posedge MCLK);
		PSEL <= 1;
		PWRITE <= w;
		PADDR <= a;
		PWDATA <= d;
		@(posedge MCLK);
		PENABLE <= 1;
		n = 0;
		do begin
			@(posedge MCLK);
			n++;
		end while (PREADY !== 1'b1 && n < 9);
		if (PREADY !== 1'b1) begin
			errors++;
			$display("ERROR apb_ready exp 1 seen %b", PREADY);
			end_sim();
		end
		rd = PRDATA;
		err = PSLVERR;
		PSEL <= 0;
		PENABLE <= 0;
	endtask
	task automatic rdchk(string nm, logic [7:0] a, logic [31:0] e);
		apb(0, a, 0);
		chk(nm, rd, e);
	endtask
	task automatic wait_rst(int lim);
		for (c = 0; c < lim && CHIP_RESTART !== 1; c++) @(negedge MCLK);
	endtask
	initial begin
		repeat (4) @(posedge MCLK);
		NRST <= 1;
		rdchk("load", 8'h04, 32'hffffff);
		rdchk("tick", 8'h10, 32'h00c);
		apb(0, 8'h30, 0);
		chk("slverr", err, 1);
		apb(1, 8'h50, 32'h5a5a0001);
		apb(1, 8'h04, 20);
		apb(1, 8'h10, 32'h20c);
		apb(1, 8'h20, 1);
		apb(1, 8'h00, 1);
		wait_rst(600);
		chk("tmo_time", c inside {[455:490]}, 1);
		rdchk("cause", 8'h0c, 1);
		chk("irq", IRQ, 1);
		rdchk("scr4", 8'h50, 32'h5a5a0001);
		apb(1, 8'h24, 7);
		rdchk("count", 8'h08, 20);
		chk("irq", IRQ, 0);
		apb(1, 8'h00, 1);
		repeat (5) begin
			wait_rst(300);
			chk("no_rst", c, 300);
			apb(1, 8'h04, 20);
		end
		rdchk("istat", 8'h1c, 4);
		chk("irq_mask", IRQ, 0);
		apb(1, 8'h00, 3);
		DBG_HALT <= 1;
		wait_rst(800);
		chk("paused", c, 800);
		DBG_HALT <= 0;
		wait_rst(600);
		chk("resumed", c < 600, 1);
		apb(1, 8'h14, 32'h1000);
		apb(1, 8'h18, 32'h2000);
		apb(1, 8'h00, 4);
		wait_rst(9);
		chk("frc_time", c < 9, 1);
		rdchk("cause", 8'h0c, 2);
		chk("jump", BOOT_JUMP, 1);
		chk("pc", BOOT_PC, 32'h1000);
		chk("sp", BOOT_SP, 32'h2000);
		apb(1, 8'h14, 0);
		apb(1, 8'h00, 4);
		wait_rst(9);
		chk("frc_time2", c < 9, 1);
		rdchk("cause", 8'h0c, 2);
		chk("jump", BOOT_JUMP, 0);
		apb(1, 8'h04, 32'd8388000);
		rdchk("load_max", 8'h04, 32'd8388000);
		NRST <= 0;
		repeat (2) @(posedge MCLK);
		NRST <= 1;
		rdchk("cause", 8'h0c, 0);
		end_sim();
	end
endmodule
`default_nettype wire
